/* logic/fan_pwm_pkg.sv */
package fan_pwm_pkg;
    // system clock and timebase
    localparam int CLK_HZ = 10_000_000;
    localparam int TB_FREQ_HZ = 30;
    localparam int TB_PERIOD_CYCLES = CLK_HZ / TB_FREQ_HZ;

    // control levels are in tenths of a percent of supply (1000 = supply)
    localparam int LEVEL_W = 10;
    localparam logic [9:0] LVL_PWM_MIN = 10'h12c;  // 30.0 %
    localparam logic [9:0] LVL_PWM_MAX = 10'h2bc;  // 70.0 %
    localparam logic [9:0] LVL_OVERTEMP = 10'h302; // 70 % + 7 %
    localparam logic [9:0] LVL_HYST = 10'h06e;     // 11.0 %
    localparam logic [9:0] LVL_GROUND = 10'h000;

    // pwm period is split into as many steps as the control span holds
    localparam int PWM_STEPS = 400;
    localparam int STEP_W = 9;
    localparam logic [8:0] STEP_LAST = 9'h18f;
    localparam logic [8:0] DUTY_FULL = 9'h190;
    localparam logic [8:0] DUTY_ZERO = 9'h000;

    localparam int STARTUP_PERIODS = 64;
    localparam logic [6:0] STARTUP_LAST = 7'h3f;

    // register map, byte addresses
    localparam logic [3:0] REG_SLOT = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LEVELS = 4'h8;
    localparam int SLOT_W = 16;

    // status fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_FAULT_BIT = 3;
    localparam int ST_DRIVE_BIT = 4;
    localparam int ST_SLPEN_BIT = 5;
    localparam int ST_DUTY_LSB = 16;
    localparam int LV_SEC_LSB = 16;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_STARTUP = 3'b001,
        ST_RUN = 3'b010,
        ST_SLEEP = 3'b011,
        ST_SHUTDOWN = 3'b100
    } seq_state_t;
endpackage

/* logic/thermal_fan_pwm_sequencer.sv */
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
// How it works
// - one internal timebase clocks the sequencer and sets the pwm period.
// - duty follows the larger of the primary and secondary control inputs.
// - control 30 to 70 percent maps linearly to 0 to 100 percent duty.
// - a full reset happens when power first comes up.
// - primary below shutdown threshold shuts down at once, no timebase wait.
// - while shut down the fan drive is off and the fault is inactive.
// - primary above restart threshold restarts exactly like a powerup.
// - any fan start from off forces the drive high for 64 periods.
// - after the startup interval normal pwm runs from the larger input.
// - fault output is active low, open collector, while overtemperature.
// - overtemperature is primary more than 7 percent above full duty.
// - overtemperature check is independent; pwm keeps running at full duty.
// - fault clears at the next period edge once primary is no longer above overtemperature level.
// - both inputs below the sleep threshold enter sleep, fan stops.
// - sleep exits only when an input passes sleep threshold plus hysteresis.
// - in sleep the fault is inactive, pwm is off and the drive floats.
// - sleep exit behaves like powerup, with the forced startup interval.
// - after powerup or reset exit, no fan start until an input passes wake.
// - at powerup the drive is low and the fault inactive before startup.
// - primary below shutdown threshold at powerup keeps the part shut down.
// - shutdown beats every other state, whatever the secondary input does.
module thermal_fan_pwm_sequencer
    import fan_pwm_pkg::*;
#(
    parameter int TB_PERIOD = fan_pwm_pkg::TB_PERIOD_CYCLES
) (
    input wire logic clk_i,                    // 10 MHz system clock
    input wire logic rst_i,                    // sync reset, active high
    input wire logic [fan_pwm_pkg::LEVEL_W-1:0] primary_control_input_i,
                                               // primary level, 0.1 %
    input wire logic [fan_pwm_pkg::LEVEL_W-1:0] secondary_control_input_i,
                                               // secondary level, 0.1 %
    input wire logic [fan_pwm_pkg::LEVEL_W-1:0] sleep_threshold_input_i,
                                               // sleep threshold, 0.1 %
    input wire logic shutdown_cmp_i,           // primary below shutdown level
    input wire logic restart_cmp_i,            // primary above restart level
    output logic fan_drive_o,                  // fan drive data
    output logic fan_drive_oe_n_o,             // low while drive is driven
    output logic overtemp_fault_n_o,           // fault pin data, active low
    output logic overtemp_fault_oe_n_o,        // low while fault pulls low
    input wire logic wb_cyc_i,                 // wishbone cycle
    input wire logic wb_stb_i,                 // wishbone strobe
    input wire logic wb_we_i,                  // wishbone write enable
    input wire logic [3:0] wb_adr_i,           // wishbone byte address
    input wire logic [3:0] wb_sel_i,           // wishbone byte selects
    input wire logic [31:0] wb_dat_i,          // wishbone write data
    output logic [31:0] wb_dat_o,              // wishbone read data
    output logic wb_ack_o                      // wishbone acknowledge
);
    import fan_pwm_pkg::*;

    localparam logic [SLOT_W-1:0] SLOT_RST = SLOT_W'(TB_PERIOD / PWM_STEPS);

    // input synchronisers: first stage is read only by the second
    logic [LEVEL_W-1:0] pri_m_r, pri_a_r, pri_b_r, pri_s_r;
    logic [LEVEL_W-1:0] sec_m_r, sec_a_r, sec_b_r, sec_s_r;
    logic [LEVEL_W-1:0] slp_m_r, slp_a_r, slp_b_r, slp_s_r;
    logic shdn_m_r, shdn_s_r;
    logic rst_m_r, rst_s_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shdn_m_r <= 1'b0;
            shdn_s_r <= 1'b0;
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            shdn_m_r <= shutdown_cmp_i;
            shdn_s_r <= shdn_m_r;
            rst_m_r <= restart_cmp_i;
            rst_s_r <= rst_m_r;
        end
    end

    // level words may tear while their bits cross; a word is taken only
    // once two synchronised samples in a row agree, two clocks later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pri_m_r <= '0;
            pri_a_r <= '0;
            pri_b_r <= '0;
            pri_s_r <= '0;
            sec_m_r <= '0;
            sec_a_r <= '0;
            sec_b_r <= '0;
            sec_s_r <= '0;
            slp_m_r <= '0;
            slp_a_r <= '0;
            slp_b_r <= '0;
            slp_s_r <= '0;
        end else begin
            pri_m_r <= primary_control_input_i;
            pri_a_r <= pri_m_r;
            pri_b_r <= pri_a_r;
            sec_m_r <= secondary_control_input_i;
            sec_a_r <= sec_m_r;
            sec_b_r <= sec_a_r;
            slp_m_r <= sleep_threshold_input_i;
            slp_a_r <= slp_m_r;
            slp_b_r <= slp_a_r;
            if (pri_a_r == pri_b_r) begin
                pri_s_r <= pri_b_r;
            end
            if (sec_a_r == sec_b_r) begin
                sec_s_r <= sec_b_r;
            end
            if (slp_a_r == slp_b_r) begin
                slp_s_r <= slp_b_r;
            end
        end
    end

    // timebase: slot length stands in for the external capacitor
    logic [SLOT_W-1:0] slot_len_r;
    logic [SLOT_W-1:0] slot_cnt_r;
    logic [STEP_W-1:0] step_cnt_r;
    logic step_tick;
    logic tb_tick;

    assign step_tick = (slot_cnt_r >= slot_len_r - SLOT_W'(1));
    assign tb_tick = step_tick && (step_cnt_r == STEP_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_cnt_r <= '0;
            step_cnt_r <= '0;
        end else if (step_tick) begin
            slot_cnt_r <= '0;
            // free running, never held by state
            step_cnt_r <= tb_tick ? '0 : step_cnt_r + STEP_W'(1);
        end else begin
            slot_cnt_r <= slot_cnt_r + SLOT_W'(1);
        end
    end

    // per-period comparator decisions
    logic [LEVEL_W-1:0] lvl_max;
    logic [LEVEL_W:0] wake_lvl;
    logic sleep_en;
    logic sleep_r, wake_r, ot_r, restart_r;
    logic [STEP_W-1:0] duty_r;
    logic [LEVEL_W-1:0] pri_samp_r, sec_samp_r;

    assign lvl_max = (pri_s_r > sec_s_r) ? pri_s_r : sec_s_r;
    assign wake_lvl = {1'b0, slp_s_r} + {1'b0, LVL_HYST};
    assign sleep_en = (slp_s_r != LVL_GROUND);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_r <= 1'b0;
            wake_r <= 1'b0;
            ot_r <= 1'b0;
            restart_r <= 1'b0;
            pri_samp_r <= '0;
            sec_samp_r <= '0;
        end else if (tb_tick) begin
            sleep_r <= sleep_en && (pri_s_r < slp_s_r)
                && (sec_s_r < slp_s_r);
            wake_r <= ({1'b0, pri_s_r} > wake_lvl)
                || ({1'b0, sec_s_r} > wake_lvl);
            ot_r <= (pri_s_r > LVL_OVERTEMP);
            restart_r <= rst_s_r;
            pri_samp_r <= pri_s_r;
            sec_samp_r <= sec_s_r;
        end else if (shdn_s_r) begin
            // a shutdown shorter than one period must not keep an old restart
            restart_r <= 1'b0;
        end
    end

    // duty code, latched per period so a period is never torn
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_r <= DUTY_ZERO;
        end else if (tb_tick) begin
            if (lvl_max >= LVL_PWM_MAX) begin
                duty_r <= DUTY_FULL;
            end else if (lvl_max <= LVL_PWM_MIN) begin
                duty_r <= DUTY_ZERO;
            end else begin
                duty_r <= STEP_W'(lvl_max - LVL_PWM_MIN);
            end
        end
    end

    // sequencer
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [6:0] start_cnt_r;

    always_comb begin
        state_nxt = state_r;
        if (shdn_s_r) begin
            // checked every clock, not only at period edges
            state_nxt = ST_SHUTDOWN;
        end else if (tb_tick) begin
            case (state_r)
                ST_IDLE: begin
                    if (wake_r) begin
                        state_nxt = ST_STARTUP;
                    end
                end
                ST_STARTUP: begin
                    if (start_cnt_r == STARTUP_LAST) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (sleep_r) begin
                        state_nxt = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_r) begin
                        state_nxt = ST_STARTUP;
                    end
                end
                ST_SHUTDOWN: begin
                    if (restart_r) begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_cnt_r <= '0;
        end else if (state_r != ST_STARTUP) begin
            start_cnt_r <= '0;
        end else if (tb_tick) begin
            start_cnt_r <= start_cnt_r + 7'h01;
        end
    end

    // pin drivers, decided from the next state so shutdown lands at once
    logic drive_nxt;
    logic drive_oe_n_nxt;
    logic fault_n_nxt;
    logic fault_n_r;

    always_comb begin
        drive_nxt = 1'b0;
        drive_oe_n_nxt = 1'b0;
        fault_n_nxt = 1'b1;
        case (state_nxt)
            ST_IDLE: begin
                drive_nxt = 1'b0;
            end
            ST_STARTUP: begin
                drive_nxt = 1'b1;
                fault_n_nxt = ~ot_r;
            end
            ST_RUN: begin
                drive_nxt = (step_cnt_r < duty_r);
                fault_n_nxt = ~ot_r;
            end
            ST_SLEEP: begin
                drive_oe_n_nxt = 1'b1;
            end
            ST_SHUTDOWN: begin
                drive_nxt = 1'b0;
            end
            default: begin
                drive_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fan_drive_o <= 1'b0;
            fan_drive_oe_n_o <= 1'b0;
            fault_n_r <= 1'b1;
            overtemp_fault_n_o <= 1'b1;
            overtemp_fault_oe_n_o <= 1'b1;
        end else begin
            fan_drive_o <= drive_nxt;
            fan_drive_oe_n_o <= drive_oe_n_nxt;
            fault_n_r <= fault_n_nxt;
            // open collector: data pin is only low when pulled
            overtemp_fault_n_o <= fault_n_nxt;
            overtemp_fault_oe_n_o <= fault_n_nxt;
        end
    end

    // wishbone slave: ack one clock after the request, unmapped reads give
    // zero; a write lands at the edge where the master sees ack high
    logic req;
    logic [31:0] rdata;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            REG_SLOT: begin
                rdata[SLOT_W-1:0] = slot_len_r;
            end
            REG_STATUS: begin
                rdata[ST_STATE_LSB +: 3] = state_r;
                rdata[ST_FAULT_BIT] = ~fault_n_r;
                rdata[ST_DRIVE_BIT] = fan_drive_o;
                rdata[ST_SLPEN_BIT] = sleep_en;
                rdata[ST_DUTY_LSB +: STEP_W] = duty_r;
            end
            REG_LEVELS: begin
                rdata[LEVEL_W-1:0] = pri_samp_r;
                rdata[LV_SEC_LSB +: LEVEL_W] = sec_samp_r;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rdata : 32'h0000_0000;
        end
    end

    // zero slot length would stall the timebase, so it is refused,
    // whether written whole or left behind by a single byte write
    logic wr_take;
    logic [SLOT_W-1:0] slot_new;

    assign wr_take = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

    always_comb begin
        slot_new = slot_len_r;
        if (wb_sel_i[0]) begin
            slot_new[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            slot_new[15:8] = wb_dat_i[15:8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_len_r <= SLOT_RST;
        end else if (wr_take && wb_adr_i == REG_SLOT) begin
            if (slot_new != '0) begin
                slot_len_r <= slot_new;
            end
        end
    end
endmodule

/* bench/fan_seq_asserts.sv */
`timescale 1ns/10ps
module fan_seq_asserts #(
    parameter int TB_PERIOD = 1200 // timebase length
) (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic shutdown_cmp_i, // shutdown decision
    input wire logic fan_drive_o, // drive data
    input wire logic fan_drive_oe_n_o, // drive enable
    input wire logic overtemp_fault_n_o, // fault data
    input wire logic overtemp_fault_oe_n_o, // fault enable
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o // ack
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // two sync stages plus the output flop
    sequence shut_s;
        shutdown_cmp_i [*4];
    endsequence
    a_shut_drive_off: assert property (
        shut_s |-> !fan_drive_o && !fan_drive_oe_n_o
        && overtemp_fault_oe_n_o)
        else $error("drive or fault active in shutdown");
    a_float_no_fault: assert property (
        fan_drive_oe_n_o |-> overtemp_fault_oe_n_o)
        else $error("fault active while drive floats");
    a_fault_pin_low: assert property (
        !overtemp_fault_oe_n_o |-> !overtemp_fault_n_o)
        else $error("fault enabled but not low");
    a_reset_outputs: assert property (
        $fell(rst_i) |-> !fan_drive_o && !fan_drive_oe_n_o
        && overtemp_fault_n_o && overtemp_fault_oe_n_o)
        else $error("outputs wrong after reset");
    a_ack_answer: assert property (req_s |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
endmodule
bind thermal_fan_pwm_sequencer fan_seq_asserts #(.TB_PERIOD(TB_PERIOD))
    i_fan_seq_asserts (.clk_i, .rst_i, .shutdown_cmp_i, .fan_drive_o,
    .fan_drive_oe_n_o, .overtemp_fault_n_o, .overtemp_fault_oe_n_o,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);

/* bench/fan_env.sv */
`timescale 1ns/10ps
module fan_env #(
    parameter int SHUT_LVL = 60, // shutdown level, 0.1 %
    parameter int RESTART_LVL = 90 // restart level, 0.1 %
) (
    input wire logic clk_i, // clock
    input wire logic drive_i, // drive data
    input wire logic drive_oe_n_i, // drive enable
    input wire logic [9:0] primary_i, // divider level
    output logic shutdown_o, // below shutdown level
    output logic restart_o // above restart level
);
    logic fan_on;
    // a floating drive is pulled off by the transistor base resistor
    assign fan_on = drive_i && !drive_oe_n_i;
    assign shutdown_o = primary_i < SHUT_LVL;
    assign restart_o = primary_i > RESTART_LVL;
    task automatic measure(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge clk_i);
            cnt += (fan_on === 1'b1);
        end
    endtask
endmodule

/* bench/thermal_fan_pwm_sequencer_tb.sv */
`timescale 1ns/10ps
module thermal_fan_pwm_sequencer_tb;
    import fan_pwm_pkg::*;
    localparam int TBP = 1200;
    localparam int PER = 400; // period once slot is set to 1
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [9:0] primary_control_input_i = 10'h014;
    logic [9:0] secondary_control_input_i = 10'h000;
    logic [9:0] sleep_threshold_input_i = 10'h000;
    logic shutdown_cmp_i, restart_cmp_i, wb_ack_o;
    logic fan_drive_o, fan_drive_oe_n_o;
    logic overtemp_fault_n_o, overtemp_fault_oe_n_o;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, rd;
    int bad_count = 0;
    int n_tests = 0;
    int cyc_n = 0;
    int cnt;
    int lv[5] = '{500, 450, 300, 700, 750};
    int dq[5] = '{200, 150, 0, 400, 400};

    always #50 clk_i = ~clk_i;

    thermal_fan_pwm_sequencer #(.TB_PERIOD(TBP)) i_thermal_fan_pwm_sequencer (
        .clk_i, .rst_i, .primary_control_input_i, .secondary_control_input_i,
        .sleep_threshold_input_i, .shutdown_cmp_i, .restart_cmp_i,
        .fan_drive_o, .fan_drive_oe_n_o, .overtemp_fault_n_o,
        .overtemp_fault_oe_n_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    fan_env i_fan_env (.clk_i, .drive_i(fan_drive_o),
        .drive_oe_n_i(fan_drive_oe_n_o), .primary_i(primary_control_input_i),
        .shutdown_o(shutdown_cmp_i), .restart_o(restart_cmp_i));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 90000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wait_state(input logic [2:0] s, input int tries);
        repeat (tries) begin
            wb(1'b0, REG_STATUS, 32'h0000_0000);
            if (rd[2:0] === s)
                break;
            repeat (PER / 4) @(posedge clk_i);
        end
        check("state", rd[2:0], s);
    endtask

    task automatic lvl(input logic [9:0] p, s);
        @(posedge clk_i);
        primary_control_input_i <= p;
        secondary_control_input_i <= s;
    endtask

    // settle three periods since decisions lag one tick
    task automatic duty(input logic [9:0] p, s, input int exp);
        lvl(p, s);
        repeat (3 * PER) @(posedge clk_i);
        i_fan_env.measure(PER, cnt);
        check("duty", cnt, exp);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        check("duty code", rd[ST_DUTY_LSB +: 9], exp);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, REG_SLOT, 32'h0000_0000);
        check("slot reset", rd, TBP / 400);
        wb(1'b1, REG_SLOT, 32'h0000_0001);
        wb(1'b1, REG_STATUS, 32'hffff_ffff);
        wb(1'b0, REG_SLOT, 32'h0000_0000);
        check("slot", rd, 32'h0000_0001);
        wb(1'b0, 4'hc, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        wait_state(ST_SHUTDOWN, 20);
        lvl(10'h064, 10'h000);
        wait_state(ST_IDLE, 20);
        repeat (5 * PER) @(posedge clk_i);
        wait_state(ST_IDLE, 1);
        lvl(10'h1f4, 10'h000);
        wait_state(ST_STARTUP, 20);
        i_fan_env.measure(60 * PER, cnt);
        check("startup high", cnt, 60 * PER);
        wait_state(ST_RUN, 40);
        check("sleep off", rd[ST_SLPEN_BIT], 0);
        $display("test powerup done");
        for (int i = 0; i < 5; i++)
            duty(lv[i][9:0], 10'h000, dq[i]);
        duty(10'h1f4, 10'h258, 300);
        wb(1'b0, REG_LEVELS, 32'h0000_0000);
        check("levels", rd, 32'h0258_01f4);
        $display("test duty done");
        duty(10'h30c, 10'h000, 400);
        check("fault", {overtemp_fault_n_o, overtemp_fault_oe_n_o}, 0);
        check("fault bit", rd[ST_FAULT_BIT], 1);
        duty(10'h302, 10'h000, 400);
        check("fault off", overtemp_fault_n_o, 1);
        check("fault released", overtemp_fault_oe_n_o, 1);
        $display("test overtemp done");
        sleep_threshold_input_i <= 10'h15e;
        lvl(10'h154, 10'h12c);
        wait_state(ST_SLEEP, 40);
        check("sleep enable", rd[ST_SLPEN_BIT], 1);
        check("drive float", fan_drive_oe_n_o, 1);
        check("sleep fault", overtemp_fault_oe_n_o, 1);
        lvl(10'h1c2, 10'h12c);
        repeat (4 * PER) @(posedge clk_i);
        wait_state(ST_SLEEP, 1);
        lvl(10'h1d6, 10'h12c);
        wait_state(ST_STARTUP, 40);
        check("wake drive", fan_drive_o, 1);
        $display("test sleep done");
        lvl(10'h014, 10'h384);
        repeat (4) @(posedge clk_i);
        check("shut pins", {fan_drive_o, fan_drive_oe_n_o}, 0);
        check("shut fault", overtemp_fault_oe_n_o, 1);
        wait_state(ST_SHUTDOWN, 20);
        $display("test shutdown done");
        end_of_test();
    end
endmodule
